// ==== hw/ocg_clock_gen.sv ====
// Notes on behaviour
// - low-speed stop sets flag 5; auto-trim done sets flag 4
// - writing one clears a flag; writing zero leaves it alone
// - stabilisation done sets flag 2 high, 1 low, 0 internal speed
// - internal stabilisation flag reads zero after reset release
// - enable bits 5 and 4 gate stop and trim interrupts
// - enable bits 2, 1, 0 gate the three stabilisation interrupts
// - source field picks internal, low, high speed or system clock
// - divider field divides internal and high speed by 1 to 128
// - system clock source stops output during sleep and halt
// - enable bit 0 gates the divided clock onto the pin
// - enable is not aligned to the clock, so glitches may appear
`timescale 1ns/1ps
`default_nettype none
module ocg_clock_gen
   import ocg_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [DATA_W-1:0] reg_rdata,
   input  wire logic              ev_lowspeed_stop,
   input  wire logic              ev_autotrim_done,
   input  wire logic              ev_highspeed_stable,
   input  wire logic              ev_lowspeed_stable,
   input  wire logic              ev_internal_stable,
   input  wire logic              internal_osc_clock,
   input  wire logic              lowspeed_osc_clock,
   input  wire logic              highspeed_osc_clock,
   input  wire logic              system_clock,
   input  wire logic              system_clock_standby,
   output logic                   irq,
   output logic                   clock_output_pin
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------

   // address match, used by every register and the read mux
   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // half-period in source edges for a source and divider code
   function automatic logic [HALF_W-1:0] div_half(
      input ocg_src_t         s,
      input logic [DIV_W-1:0] d);
      logic [HALF_W-1:0] h;
      h = HALF_BYP;
      case (s)
         SRC_INT, SRC_HS:
         begin
            if (d != RST_DIV)
               h = HALF_ONE << (d - 3'h1);
         end
         SRC_LS:
         begin
            if (d == RST_DIV)
               h = HALF_BYP;
            else if (d <= DIV_LS_WIDE)
               h = HALF_ONE << (d - 3'h1);
            else if (d == 3'h4)
               h = LS_HALF_256;
            else if (d == 3'h5)
               h = LS_HALF_1K;
            else if (d == 3'h6)
               h = LS_HALF_4K;
            else
               h = LS_HALF_32K;
         end
         default: h = HALF_BYP; // system clock source falls back to 1/1
      endcase
      div_half = h;
   endfunction

   // ------------------------------------------------------------
   // register state
   // ------------------------------------------------------------
   logic [FLAG_W-1:0] flag_q;
   logic [FLAG_W-1:0] flag_d;
   logic [FLAG_W-1:0] flag_clr;
   logic [FLAG_W-1:0] ev_vec;
   logic [FLAG_W-1:0] ena_q;
   logic [FLAG_W-1:0] ena_d;
   logic [DIV_W-1:0]  div_q;
   ocg_src_t          src_q;
   logic              en_q;
   logic [DATA_W-1:0] rd_d;
   logic [DATA_W-1:0] rd_q;
   logic              irq_q;
   logic              wr_flags;
   logic              wr_ena;
   logic              wr_out;

   assign wr_flags = reg_wr && hit(reg_addr, OFF_FLAGS);
   assign wr_ena   = reg_wr && hit(reg_addr, OFF_ENA);
   assign wr_out   = reg_wr && hit(reg_addr, OFF_OUT);

   // ------------------------------------------------------------
   // event flags
   // ------------------------------------------------------------

   // events are one-cycle pulses from oscillator logic on mclk
   assign ev_vec[BIT_LS_STOP] = ev_lowspeed_stop;
   assign ev_vec[BIT_TRIM]    = ev_autotrim_done;
   assign ev_vec[BIT_RSV]     = 1'b0;
   assign ev_vec[BIT_HS_STA]  = ev_highspeed_stable;
   assign ev_vec[BIT_LS_STA]  = ev_lowspeed_stable;
   assign ev_vec[BIT_IN_STA]  = ev_internal_stable;

   // write-one-to-clear; a same-cycle event beats the clear
   always_comb
   begin
      flag_clr = '0;
      if (wr_flags)
         flag_clr = reg_wdata[FLAG_W-1:0] & IMPL_MASK;
      flag_d = (flag_q & ~flag_clr) | (ev_vec & IMPL_MASK);
   end

   // flags start clear, even the internal-stable one
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         flag_q <= RST_FLAGS;
      else if (clk_en)
         flag_q <= flag_d;
   end

   // ------------------------------------------------------------
   // interrupt enables and request
   // ------------------------------------------------------------

   // enable register, reserved bits never stored
   always_comb
   begin
      ena_d = ena_q;
      if (wr_ena)
         ena_d = reg_wdata[FLAG_W-1:0] & IMPL_MASK;
   end

   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         ena_q <= RST_ENA;
      else if (clk_en)
         ena_q <= ena_d;
   end

   // request registered from next values so it tracks the flags
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         irq_q <= 1'b0;
      else if (clk_en)
         irq_q <= |(flag_d & ena_d);
   end

   assign irq = irq_q;

   // ------------------------------------------------------------
   // clock output control
   // ------------------------------------------------------------

   // source, ratio and pin enable fields
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         div_q <= RST_DIV;
         src_q <= SRC_INT;
         en_q  <= 1'b0;
      end
      else if (clk_en && wr_out)
      begin
         div_q <= reg_wdata[DIV_LO +: DIV_W];
         src_q <= ocg_src_t'(reg_wdata[SRC_LO +: SRC_W]);
         en_q  <= reg_wdata[EN_BIT];
      end
   end

   // ------------------------------------------------------------
   // register read
   // ------------------------------------------------------------

   // unmapped addresses and reserved bits read as zero
   always_comb
   begin
      rd_d = '0;
      if (hit(reg_addr, OFF_FLAGS))
         rd_d = DATA_W'(flag_q);
      else if (hit(reg_addr, OFF_ENA))
         rd_d = DATA_W'(ena_q);
      else if (hit(reg_addr, OFF_OUT))
      begin
         rd_d[EN_BIT]          = en_q;
         rd_d[SRC_LO +: SRC_W] = src_q;
         rd_d[DIV_LO +: DIV_W] = div_q;
      end
   end

   // data stand one cycle after the strobe and only then
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         rd_q <= '0;
      else if (clk_en)
         rd_q <= reg_rd ? rd_d : '0;
   end

   assign reg_rdata = rd_q;

   // ------------------------------------------------------------
   // source sampling and selection
   // ------------------------------------------------------------
   logic [3:0]        src_sync;
   logic [3:0]        src_prev_q;
   logic [3:0]        src_rise;
   logic              sel_lvl;
   logic              sel_tick;
   logic              sel_stop;
   logic [HALF_W-1:0] half;

   // oscillator clocks are sampled, so each must stay below mclk/2
   ocg_sync #(
      .W (4)
   ) u_sync (
      .mclk   (mclk),
      .resetn (resetn),
      .clk_en (clk_en),
      .din    ({system_clock, highspeed_osc_clock,
                lowspeed_osc_clock, internal_osc_clock}),
      .dout   (src_sync)
   );

   // rising-edge detect on the synchronised levels
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
         src_prev_q <= '0;
      else if (clk_en)
         src_prev_q <= src_sync;
   end

   assign src_rise = src_sync & ~src_prev_q;

   // system clock is absent in sleep and halt, so output stalls
   assign sel_stop = (src_q == SRC_SYS) && system_clock_standby;
   assign sel_lvl  = src_sync[src_q];
   assign sel_tick = src_rise[src_q] && !sel_stop;
   assign half     = div_half(src_q, div_q);

   // ------------------------------------------------------------
   // divider and pin
   // ------------------------------------------------------------

   // enable goes straight in, unaligned to the source phase
   ocg_clk_div #(
      .HALF_W (HALF_W)
   ) u_div (
      .mclk    (mclk),
      .resetn  (resetn),
      .clk_en  (clk_en),
      .run     (en_q),
      .freeze  (sel_stop),
      .half    (half),
      .tick    (sel_tick),
      .lvl     (sel_lvl),
      .div_out (clock_output_pin)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   sequence s_out_off;
      clk_en && wr_out && !reg_wdata[EN_BIT] ##1 clk_en;
   endsequence

   sequence s_flag_zero_wr;
      clk_en && wr_flags && reg_wdata[FLAG_W-1:0] == RST_FLAGS;
   endsequence

   a_stop_set: assert property (
      clk_en && ev_lowspeed_stop |=> flag_q[BIT_LS_STOP])
      else $error("stop event did not set its flag");
   a_trim_set: assert property (
      clk_en && ev_autotrim_done |=> flag_q[BIT_TRIM])
      else $error("trim event did not set its flag");
   a_one_clears: assert property (
      clk_en && wr_flags && !(|ev_vec)
      |=> (flag_q & $past(reg_wdata[FLAG_W-1:0]) & IMPL_MASK) == '0)
      else $error("write of one did not clear a flag");
   a_zero_keeps: assert property (
      s_flag_zero_wr |=> ($past(flag_q) & ~flag_q) == '0)
      else $error("write of zero dropped a flag");
   a_stable_set: assert property (
      clk_en && (|ev_vec[BIT_HS_STA:BIT_IN_STA])
      |=> (flag_q[BIT_HS_STA:BIT_IN_STA]
           & $past(ev_vec[BIT_HS_STA:BIT_IN_STA]))
          == $past(ev_vec[BIT_HS_STA:BIT_IN_STA]))
      else $error("stabilisation event did not set its flag");
   a_int_cause: assert property (
      $rose(flag_q[BIT_IN_STA]) |-> $past(ev_internal_stable))
      else $error("internal-stable flag rose with no event");
   a_stop_irq: assert property (
      clk_en && ev_lowspeed_stop && ena_d[BIT_LS_STOP] |=> irq)
      else $error("enabled stop event gave no request");
   a_hs_irq: assert property (
      clk_en && ev_highspeed_stable && ena_d[BIT_HS_STA] |=> irq)
      else $error("enabled stabilisation event gave no request");
   a_irq_hold: assert property (
      irq && !reg_wr |=> irq)
      else $error("request dropped without a register write");
   a_sys_ratio: assert property (
      src_q == SRC_SYS |-> half == HALF_BYP)
      else $error("system clock source not divided by one");
   a_standby_stop: assert property (
      clk_en && sel_stop && en_q |=> $stable(clock_output_pin))
      else $error("output moved while system clock stopped");
   a_pin_off: assert property (
      s_out_off |=> !clock_output_pin)
      else $error("pin not low after disable");
endmodule
`default_nettype wire

// ==== shared/ocg_pkg.sv ====
`default_nettype none
package ocg_pkg;
   // ------------------------------------------------------------
   // bus geometry and register offsets
   // ------------------------------------------------------------
   localparam int              ADDR_W    = 4;
   localparam int              DATA_W    = 16;
   localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h0;
   localparam logic [ADDR_W-1:0] OFF_ENA   = 4'h2;
   localparam logic [ADDR_W-1:0] OFF_OUT   = 4'h4;
   // ------------------------------------------------------------
   // flag and enable layout
   // ------------------------------------------------------------
   localparam int              FLAG_W      = 6;
   localparam int              BIT_LS_STOP = 5;
   localparam int              BIT_TRIM    = 4;
   localparam int              BIT_RSV     = 3;
   localparam int              BIT_HS_STA  = 2;
   localparam int              BIT_LS_STA  = 1;
   localparam int              BIT_IN_STA  = 0;
   localparam logic [FLAG_W-1:0] IMPL_MASK = 6'h37;
   localparam logic [FLAG_W-1:0] RST_FLAGS = 6'h00;
   localparam logic [FLAG_W-1:0] RST_ENA   = 6'h00;
   // ------------------------------------------------------------
   // clock output control layout
   // ------------------------------------------------------------
   localparam int              EN_BIT  = 0;
   localparam int              SRC_LO  = 2;
   localparam int              SRC_W   = 2;
   localparam int              DIV_LO  = 4;
   localparam int              DIV_W   = 3;
   localparam logic [DIV_W-1:0] RST_DIV = 3'h0;
   localparam logic [DIV_W-1:0] DIV_LS_WIDE = 3'h3;
   typedef enum logic [SRC_W-1:0] {
      SRC_INT = 2'h0,
      SRC_LS  = 2'h1,
      SRC_HS  = 2'h2,
      SRC_SYS = 2'h3
   } ocg_src_t;
   // ------------------------------------------------------------
   // divider half-periods, zero means pass through
   // ------------------------------------------------------------
   localparam int               HALF_W      = 15;
   localparam logic [HALF_W-1:0] HALF_BYP    = 15'h0000;
   localparam logic [HALF_W-1:0] HALF_ONE    = 15'h0001;
   localparam logic [HALF_W-1:0] LS_HALF_256 = 15'h0080;
   localparam logic [HALF_W-1:0] LS_HALF_1K  = 15'h0200;
   localparam logic [HALF_W-1:0] LS_HALF_4K  = 15'h0800;
   localparam logic [HALF_W-1:0] LS_HALF_32K = 15'h4000;
endpackage
`default_nettype wire

// ==== hw/ocg_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocg_sync #(
   parameter int W = 4
) (
   input  wire logic         mclk,
   input  wire logic         resetn,
   input  wire logic         clk_en,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] s1_q;
   logic [W-1:0] s2_q;

   // two-stage synchroniser, first stage feeds only the second
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else if (clk_en)
      begin
         s1_q <= din;
         s2_q <= s1_q;
      end
   end

   assign dout = s2_q;
endmodule
`default_nettype wire

// ==== hw/ocg_clk_div.sv ====
`timescale 1ns/1ps
`default_nettype none
module ocg_clk_div #(
   parameter int HALF_W = 15
) (
   input  wire logic              mclk,
   input  wire logic              resetn,
   input  wire logic              clk_en,
   input  wire logic              run,
   input  wire logic              freeze,
   input  wire logic [HALF_W-1:0] half,
   input  wire logic              tick,
   input  wire logic              lvl,
   output logic                   div_out
);
   localparam logic [HALF_W-1:0] CNT_ONE = HALF_W'(1);
   localparam logic [HALF_W-1:0] CNT_ZERO = '0;

   logic [HALF_W-1:0] cnt_q;
   logic              q_q;

   // edge counter; cleared while off so a re-enable starts fresh
   always_ff @(posedge mclk or negedge resetn)
   begin
      if (!resetn)
      begin
         cnt_q <= CNT_ZERO;
         q_q   <= 1'b0;
      end
      else if (clk_en)
      begin
         if (!run)
         begin
            cnt_q <= CNT_ZERO;
            q_q   <= 1'b0;
         end
         else if (freeze)
         begin
            q_q <= q_q;
         end
         else if (half == CNT_ZERO)
         begin
            cnt_q <= CNT_ZERO;
            q_q   <= lvl;
         end
         else if (tick)
         begin
            // >= so a smaller ratio written mid-count cannot overrun
            if (cnt_q >= half - CNT_ONE)
            begin
               cnt_q <= CNT_ZERO;
               q_q   <= ~q_q;
            end
            else
               cnt_q <= cnt_q + CNT_ONE;
         end
      end
   end

   assign div_out = q_q;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   a_off_clears: assert property (
      clk_en && !run |=> cnt_q == CNT_ZERO && !q_q)
      else $error("divider not cleared while off");
   a_toggle_cause: assert property (
      clk_en && run && half != CNT_ZERO && !tick |=> $stable(q_q))
      else $error("divided clock moved without a source edge");
endmodule
`default_nettype wire

// ==== verif/ocg_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb
   import ocg_pkg::*;
;
   // ------------------------------------------------------------
   // stimulus and observation signals
   // ------------------------------------------------------------
   logic              mclk;
   logic              resetn;
   logic              clk_en;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic              reg_wr;
   logic              reg_rd;
   logic [DATA_W-1:0] reg_rdata;
   logic [5:0]        ev;
   logic [3:0]        src_clk;
   logic              system_clock_standby;
   logic              irq;
   logic              pin;
   logic [DATA_W-1:0] rv;
   int                mismatches;
   int                tests_run;
   int                cycles;
   int                per;
   int                sc [4];
   // source half periods in mclk cycles: int, low, high, system
   localparam int     HALF_C [4] = '{4, 4, 6, 5};

   ocg_clock_gen uut (
      .mclk                (mclk),
      .resetn              (resetn),
      .clk_en              (clk_en),
      .reg_addr            (reg_addr),
      .reg_wdata           (reg_wdata),
      .reg_wr              (reg_wr),
      .reg_rd              (reg_rd),
      .reg_rdata           (reg_rdata),
      .ev_lowspeed_stop    (ev[5]),
      .ev_autotrim_done    (ev[4]),
      .ev_highspeed_stable (ev[2]),
      .ev_lowspeed_stable  (ev[1]),
      .ev_internal_stable  (ev[0]),
      .internal_osc_clock  (src_clk[0]),
      .lowspeed_osc_clock  (src_clk[1]),
      .highspeed_osc_clock (src_clk[2]),
      .system_clock        (src_clk[3]),
      .system_clock_standby      (system_clock_standby),
      .irq                 (irq),
      .clock_output_pin    (pin)
   );

   // ------------------------------------------------------------
   // clocks and watchdog
   // ------------------------------------------------------------
   always #12.5 mclk = ~mclk;

   // slow source clocks, well under mclk/4 so the syncs see every edge
   always @(posedge mclk)
   begin
      for (int i = 0; i < 4; i++)
      begin
         if (sc[i] == HALF_C[i] - 1)
         begin
            sc[i] <= 0;
            src_clk[i] <= ~src_clk[i];
         end
         else
            sc[i] <= sc[i] + 1;
      end
   end

   // hang guard, the whole run needs roughly 10k cycles
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles == 60000)
      begin
         mismatches++;
         results();
      end
   end

   // ------------------------------------------------------------
   // bus tasks and reporting
   // ------------------------------------------------------------
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge mclk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr    <= 1'b0;
      #1;
   endtask

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge mclk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd   <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic pulse(input logic [5:0] m);
      @(posedge mclk);
      ev <= m;
      @(posedge mclk);
      ev <= 6'h00;
      #1;
   endtask

   task automatic check(input logic [DATA_W-1:0] seen,
                        input logic [DATA_W-1:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // cycles until the next rising edge of the pin, capped
   task automatic pin_rise(output int n);
      logic prev;
      n = 0;
      prev = pin;
      while (!(pin === 1'b1 && prev === 1'b0) && n < 9000)
      begin
         prev = pin;
         @(posedge mclk);
         #1;
         n++;
      end
   endtask

   // first two edges absorb the restart after a control change
   task automatic measure(output int p);
      int n;
      pin_rise(n);
      pin_rise(n);
      pin_rise(p);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic results;
      $display("compares %0d, mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   localparam int T_SRC [11] = '{0, 0, 0, 0, 0, 1, 1, 2, 2, 3, 3};
   localparam int T_DIV [11] = '{0, 1, 2, 3, 7, 3, 4, 2, 5, 0, 5};
   localparam int T_RAT [11] = '{1, 2, 4, 8, 128, 8, 256, 4, 32, 1, 1};
   localparam int EV_BITS [5] = '{5, 4, 2, 1, 0};

   initial
   begin
      logic [DATA_W-1:0] m;
      logic              p;
      mclk = 0;
      resetn = 0;
      clk_en = 1;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 0;
      reg_rd = 0;
      ev = '0;
      src_clk = '0;
      system_clock_standby = 0;
      sc = '{0, 0, 0, 0};
      mismatches = 0;
      tests_run = 0;
      cycles = 0;
      repeat (20) @(posedge mclk);
      resetn <= 1'b1;

      // reset values, reserved bits and unmapped places
      rd(OFF_FLAGS, rv); check(rv, 16'h0000);
      rd(OFF_ENA, rv);   check(rv, 16'h0000);
      rd(OFF_OUT, rv);   check(rv, 16'h0000);
      check(DATA_W'(pin), 16'h0000);
      wr(OFF_ENA, 16'hffff);
      rd(OFF_ENA, rv);   check(rv, 16'h0037);
      wr(OFF_OUT, 16'hffff);
      rd(OFF_OUT, rv);   check(rv, 16'h007d);
      wr(OFF_FLAGS, 16'hffff);
      rd(OFF_FLAGS, rv); check(rv, 16'h0000);
      wr(4'h6, 16'h0000);
      rd(4'h6, rv);      check(rv, 16'h0000);
      rd(OFF_ENA, rv);   check(rv, 16'h0037);
      wr(OFF_OUT, 16'h0000);
      // a write while frozen must be ignored
      wr(OFF_ENA, 16'h0000);
      @(posedge mclk);
      clk_en <= 1'b0;
      wr(OFF_ENA, 16'h0037);
      @(posedge mclk);
      clk_en <= 1'b1;
      rd(OFF_ENA, rv);   check(rv, 16'h0000);
      done("registers");

      // each cause: masked first, then unmasked, then cleared
      for (int i = 0; i < 5; i++)
      begin
         m = 16'h0001 << EV_BITS[i];
         wr(OFF_ENA, 16'h0037 & ~m);
         pulse(m[5:0]);
         rd(OFF_FLAGS, rv); check(rv, m);
         check(DATA_W'(irq), 16'h0000);
         wr(OFF_ENA, m);
         check(DATA_W'(irq), 16'h0001);
         wr(OFF_FLAGS, 16'h0037 & ~m);
         rd(OFF_FLAGS, rv); check(rv, m);
         check(DATA_W'(irq), 16'h0001);
         wr(OFF_FLAGS, m);
         rd(OFF_FLAGS, rv); check(rv, 16'h0000);
         check(DATA_W'(irq), 16'h0000);
         // cause arriving while already unmasked
         pulse(m[5:0]);
         check(DATA_W'(irq), 16'h0001);
         wr(OFF_FLAGS, m);
         check(DATA_W'(irq), 16'h0000);
      end
      done("events");

      // output period for every source and a spread of codes
      for (int i = 0; i < 11; i++)
      begin
         wr(OFF_OUT, 16'((T_DIV[i] << 4) | (T_SRC[i] << 2) | 1));
         measure(per);
         check(16'(per), 16'(T_RAT[i] * 2 * HALF_C[T_SRC[i]]));
      end
      done("divider");

      // system clock stopped: pin must not move
      @(posedge mclk);
      system_clock_standby <= 1'b1;
      repeat (6) @(posedge mclk);
      #1;
      p = pin;
      repeat (40)
      begin
         @(posedge mclk);
         #1;
         check(DATA_W'(pin), DATA_W'(p));
      end
      @(posedge mclk);
      system_clock_standby <= 1'b0;
      measure(per);
      check(16'(per), 16'(2 * HALF_C[3]));
      done("standby");

      // disabled pin sits low; running again after re-enable
      wr(OFF_OUT, 16'h0011);
      measure(per);
      wr(OFF_OUT, 16'h0010);
      repeat (3) @(posedge mclk);
      #1;
      repeat (40)
      begin
         @(posedge mclk);
         #1;
         check(DATA_W'(pin), 16'h0000);
      end
      wr(OFF_OUT, 16'h0011);
      measure(per);
      check(16'(per), 16'(4 * HALF_C[0]));
      done("enable");
      results();
   end
endmodule
`default_nettype wire
